// *** core/sfc_pkg.sv ***
// Package for the serial flow-control block: register map, codes, timing
package sfc_pkg;
  // Register byte offsets
  localparam logic [7:0] SFC_CTRL_OFS = 8'h00;
  localparam logic [7:0] SFC_STAT_OFS = 8'h04;
  localparam logic [7:0] SFC_IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] SFC_IRQ_MASK_OFS = 8'h0c;
  localparam logic [7:0] SFC_TXDATA_OFS = 8'h10;
  localparam logic [7:0] SFC_RXDATA_OFS = 8'h14;
  // Control field positions
  localparam int SFC_MODE_LSB = 0;
  localparam int SFC_RWAIT_LSB = 4;
  localparam int SFC_AWAIT_LSB = 8;
  localparam int SFC_MENU_BIT = 12;
  localparam logic [31:0] SFC_CTRL_RST = 32'h0000_0000;
  // Interrupt bits
  localparam int SFC_IRQ_GOOD = 0;
  localparam int SFC_IRQ_ERR = 1;
  localparam int SFC_IRQ_DONE = 2;
  localparam int SFC_IRQ_RX = 3;
  localparam int SFC_IRQ_N = 4;
  // Flow-control methods
  localparam logic [2:0] HANDSHAKE_NONE_CODE = 3'h0;
  localparam logic [2:0] HANDSHAKE_LINE_CODE = 3'h1;
  localparam logic [2:0] HANDSHAKE_REQUEST_CODE = 3'h2;
  localparam logic [2:0] HANDSHAKE_ACK_CODE = 3'h3;
  localparam logic [2:0] HANDSHAKE_ACK_QUIET_CODE = 3'h4;
  // Wait selections
  localparam logic [1:0] READY_WAIT_UNLIMITED_CODE = 2'h0;
  localparam logic [1:0] RESPONSE_WAIT_UNLIMITED_CODE = 2'h0;
  // Host response characters
  localparam logic [7:0] SFC_CHR_ACK = 8'h06;
  localparam logic [7:0] SFC_CHR_NAK = 8'h15;
  localparam logic [7:0] SFC_CHR_DC1 = 8'h11;
  // Timing
  localparam int SFC_CLK_MHZ = 100;
  localparam int SFC_MS_CYC = SFC_CLK_MHZ * 1000;
  localparam int SFC_T100_MS = 100;
  localparam int SFC_T200_MS = 200;
  localparam int SFC_T400_MS = 400;
  localparam int SFC_T500_MS = 500;
  localparam int SFC_T1000_MS = 1000;
  localparam int SFC_TMR_W = 27;
  // AXI responses
  localparam logic [1:0] SFC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SFC_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } sfc_char_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_REQ = 6'h02,
    ST_WAITRDY = 6'h04,
    ST_SEND = 6'h08,
    ST_BUSY = 6'h10,
    ST_RESP = 6'h20
  } sfc_state_t;
endpackage

// *** core/sfc_top.sv ***
// Serial flow-control engine with AXI4-Lite register access
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// (RULE1) Five methods selectable: none, ready line, request line, ack, ack quiet.
// (RULE2) No flow control: transmit without looking at host ready.
// (RULE3) Own readiness on request output; host readiness read on clear input.
// (RULE4) Ready mode: ready output high except while sending or in menu.
// (RULE5) Sample host ready before sending; start at once or wait for it.
// (RULE6) Host ready still low at wait expiry: flag error, drop transmission.
// (RULE7) Ready wait: unlimited default, 100, 200 or 400 ms.
// (RULE8) Host drops ready mid-character: finish character, then wait.
// (RULE9) Request mode raises request output before sending, else as ready mode; the code keeps it high while sending and drops it only back in idle.
// (RULE10) Ack mode: after sending, wait for response or timeout.
// (RULE11) Ack received: good-read completion, back to idle.
// (RULE12) Nak received: resend same data, wait for response again.
// (RULE13) DC1 received: back to awaiting trigger (idle).
// (RULE14) Response timeout in ack mode: flag error, back to idle.
// (RULE15) Response wait: unlimited default, 100, 500 or 1000 ms.
// (RULE16) Quiet ack mode: timeout counts as ack, no error.
// (RULE17) Framing 7/8 bits, parity, stop bits set in the external framer.
// (RULE18) Bit rate 600 to 38400 set in the external baud generator.
// (RULE19) Responses are 06, 15, 11 hex; other characters ignored while waiting.
module sfc_top
  import sfc_pkg::*;
#(
  // Clock cycles per millisecond; a smaller value shortens every timeout alike
  parameter int CYC_PER_MS = SFC_MS_CYC
)
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Character framer
  output logic [7:0] tx_data_out,
  output logic tx_start_out,
  input wire logic tx_busy_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_valid_in,
  // Handshake lines
  output logic local_ready_output_out,
  input wire logic host_ready_in,
  // Interrupt
  output logic irq_out
);

  // ----------------------------------------------------------------
  // Timeout selections
  // ----------------------------------------------------------------
  function automatic logic [SFC_TMR_W-1:0] ms_cyc(input int ms);
    ms_cyc = SFC_TMR_W'(ms * CYC_PER_MS);
  endfunction

  logic [31:0] ctrl_r, ctrl_nxt;
  logic [SFC_IRQ_N-1:0] ist_r, ist_nxt, imask_r, imask_nxt;
  logic [7:0] txbuf_r, txbuf_nxt;
  logic txpend_r, txpend_nxt;
  sfc_char_t rxlast_r, rxlast_nxt;

  logic [2:0] mode;
  logic [1:0] rwait_sel, await_sel;
  logic menu_busy;
  logic [SFC_TMR_W-1:0] rdy_lim, rsp_lim;
  assign mode = ctrl_r[SFC_MODE_LSB +: 3];
  assign rwait_sel = ctrl_r[SFC_RWAIT_LSB +: 2];
  assign await_sel = ctrl_r[SFC_AWAIT_LSB +: 2];
  assign menu_busy = ctrl_r[SFC_MENU_BIT];

  always_comb
  begin
    unique case (rwait_sel) // RULE7
      2'h1: rdy_lim = ms_cyc(SFC_T100_MS);
      2'h2: rdy_lim = ms_cyc(SFC_T200_MS);
      2'h3: rdy_lim = ms_cyc(SFC_T400_MS);
      default: rdy_lim = '0;
    endcase
    unique case (await_sel) // RULE15
      2'h1: rsp_lim = ms_cyc(SFC_T100_MS);
      2'h2: rsp_lim = ms_cyc(SFC_T500_MS);
      2'h3: rsp_lim = ms_cyc(SFC_T1000_MS);
      default: rsp_lim = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Flow-control state machine
  // ----------------------------------------------------------------
  sfc_state_t st_r, st_nxt;
  logic [SFC_TMR_W-1:0] tmr_r, tmr_nxt;
  logic start_r, start_nxt, rdy_r, rdy_nxt;
  logic ev_good, ev_err, ev_done, tx_take;
  logic line_mode, ack_mode;
  assign line_mode = (mode == HANDSHAKE_LINE_CODE) || (mode == HANDSHAKE_REQUEST_CODE);
  assign ack_mode = (mode == HANDSHAKE_ACK_CODE) || (mode == HANDSHAKE_ACK_QUIET_CODE);

  always_comb
  begin
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    start_nxt = 1'b0;
    ev_good = 1'b0;
    ev_err = 1'b0;
    ev_done = 1'b0;
    tx_take = 1'b0;
    unique case (st_r)
      ST_IDLE:
        if (txpend_r && !menu_busy)
        begin
          tmr_nxt = '0;
          if (mode == HANDSHAKE_REQUEST_CODE)
            st_nxt = ST_REQ; // RULE9
          else if (line_mode)
            st_nxt = ST_WAITRDY;
          else
            st_nxt = ST_SEND; // RULE2
        end
      ST_REQ:
        st_nxt = ST_WAITRDY; // RULE9
      ST_WAITRDY:
        if (host_ready_in) // RULE3 RULE5
          st_nxt = ST_SEND;
        else if (rdy_lim != '0 && tmr_r >= rdy_lim - 1'b1)
        begin
          ev_err = 1'b1; // RULE6
          tx_take = 1'b1;
          st_nxt = ST_IDLE;
        end
        else
          tmr_nxt = tmr_r + 1'b1;
      ST_SEND:
        if (!tx_busy_in)
        begin
          start_nxt = 1'b1;
          st_nxt = ST_BUSY;
        end
      ST_BUSY:
        // The whole character finishes before host ready is looked at again
        if (!start_r && !tx_busy_in) // RULE8
        begin
          tmr_nxt = '0;
          if (ack_mode)
            st_nxt = ST_RESP; // RULE10
          else
          begin
            ev_done = 1'b1;
            tx_take = 1'b1;
            st_nxt = ST_IDLE;
          end
        end
      ST_RESP:
        if (rx_valid_in && rx_data_in == SFC_CHR_ACK)
        begin
          ev_good = 1'b1; // RULE11
          tx_take = 1'b1;
          st_nxt = ST_IDLE;
        end
        else if (rx_valid_in && rx_data_in == SFC_CHR_NAK)
          st_nxt = ST_SEND; // RULE12
        else if (rx_valid_in && rx_data_in == SFC_CHR_DC1)
        begin
          tx_take = 1'b1; // RULE13
          st_nxt = ST_IDLE;
        end
        else if (rsp_lim != '0 && tmr_r >= rsp_lim - 1'b1)
        begin
          tx_take = 1'b1;
          if (mode == HANDSHAKE_ACK_QUIET_CODE)
            ev_good = 1'b1; // RULE16
          else
            ev_err = 1'b1; // RULE14
          st_nxt = ST_IDLE;
        end
        else
          tmr_nxt = tmr_r + 1'b1; // RULE19
    endcase
    // Ready low while sending or in menu; request mode drops it only in idle
    if (mode == HANDSHAKE_REQUEST_CODE)
      rdy_nxt = (st_nxt != ST_IDLE); // RULE9
    else
      rdy_nxt = !(menu_busy || st_nxt == ST_SEND || st_nxt == ST_BUSY); // RULE4
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!nrst_in)
    begin
      st_r <= ST_IDLE;
      tmr_r <= '0;
      start_r <= 1'b0;
      rdy_r <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      start_r <= start_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave and registers
  // ----------------------------------------------------------------
  logic awr_r, awr_nxt, wr_r, wr_nxt, bv_r, bv_nxt, arr_r, arr_nxt, rv_r, rv_nxt;
  logic [7:0] awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [3:0] ws_r, ws_nxt;
  logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
  logic have_aw_r, have_aw_nxt, have_w_r, have_w_nxt;
  logic [SFC_IRQ_N-1:0] ev_vec, w1c;
  logic do_wr;
  logic [31:0] wmask;

  assign ev_vec = {rx_valid_in, ev_done, ev_err, ev_good};

  always_comb
  begin
    have_aw_nxt = have_aw_r;
    have_w_nxt = have_w_r;
    awa_nxt = awa_r;
    wd_nxt = wd_r;
    ws_nxt = ws_r;
    if (s_axi_awvalid_in && awr_r)
    begin
      have_aw_nxt = 1'b1;
      awa_nxt = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && wr_r)
    begin
      have_w_nxt = 1'b1;
      wd_nxt = s_axi_wdata_in;
      ws_nxt = s_axi_wstrb_in;
    end
    do_wr = have_aw_r && have_w_r && !bv_r;
    wmask = {{8{ws_r[3]}}, {8{ws_r[2]}}, {8{ws_r[1]}}, {8{ws_r[0]}}};
    if (do_wr)
    begin
      have_aw_nxt = 1'b0;
      have_w_nxt = 1'b0;
    end
    awr_nxt = !have_aw_nxt && !bv_r;
    wr_nxt = !have_w_nxt && !bv_r;
    bv_nxt = do_wr || (bv_r && !s_axi_bready_in);
    br_nxt = br_r;
    ctrl_nxt = ctrl_r;
    imask_nxt = imask_r;
    txbuf_nxt = txbuf_r;
    txpend_nxt = txpend_r && !tx_take;
    w1c = '0;
    if (do_wr)
    begin
      br_nxt = SFC_RESP_OKAY;
      unique case (awa_r)
        SFC_CTRL_OFS: ctrl_nxt = (ctrl_r & ~wmask) | (wd_r & wmask); // RULE1
        SFC_IRQ_STAT_OFS: w1c = wd_r[SFC_IRQ_N-1:0] & wmask[SFC_IRQ_N-1:0];
        SFC_IRQ_MASK_OFS: imask_nxt = wd_r[SFC_IRQ_N-1:0];
        SFC_TXDATA_OFS:
          if (!txpend_r && ws_r[0])
          begin
            txbuf_nxt = wd_r[7:0];
            txpend_nxt = 1'b1;
          end
        SFC_STAT_OFS, SFC_RXDATA_OFS: ;
        default: br_nxt = SFC_RESP_SLVERR;
      endcase
    end
    // Hardware set wins over a software clear in the same cycle
    ist_nxt = (ist_r & ~w1c) | ev_vec;
    rxlast_nxt = rxlast_r;
    if (rx_valid_in)
      rxlast_nxt = '{data: rx_data_in, valid: 1'b1};
    rv_nxt = rv_r && !s_axi_rready_in;
    arr_nxt = !rv_nxt && !(s_axi_arvalid_in && arr_r);
    rd_nxt = rd_r;
    rr_nxt = rr_r;
    if (s_axi_arvalid_in && arr_r)
    begin
      rv_nxt = 1'b1;
      rr_nxt = SFC_RESP_OKAY;
      unique case (s_axi_araddr_in)
        SFC_CTRL_OFS: rd_nxt = ctrl_r;
        SFC_STAT_OFS: rd_nxt = {24'h00_0000, txpend_r, host_ready_in, st_r};
        SFC_IRQ_STAT_OFS: rd_nxt = {28'h000_0000, ist_r};
        SFC_IRQ_MASK_OFS: rd_nxt = {28'h000_0000, imask_r};
        SFC_TXDATA_OFS: rd_nxt = {24'h00_0000, txbuf_r};
        SFC_RXDATA_OFS:
        begin
          rd_nxt = {23'h00_0000, rxlast_r};
          if (!rx_valid_in)
            rxlast_nxt.valid = 1'b0;
        end
        default:
        begin
          rd_nxt = 32'h0000_0000;
          rr_nxt = SFC_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!nrst_in)
    begin
      awr_r <= 1'b0;
      wr_r <= 1'b0;
      bv_r <= 1'b0;
      br_r <= SFC_RESP_OKAY;
      arr_r <= 1'b0;
      rv_r <= 1'b0;
      rr_r <= SFC_RESP_OKAY;
      rd_r <= 32'h0000_0000;
      awa_r <= 8'h00;
      wd_r <= 32'h0000_0000;
      ws_r <= 4'h0;
      have_aw_r <= 1'b0;
      have_w_r <= 1'b0;
      ctrl_r <= SFC_CTRL_RST;
      ist_r <= '0;
      imask_r <= '0;
      txbuf_r <= 8'h00;
      txpend_r <= 1'b0;
      rxlast_r <= '0;
      irq_out <= 1'b0;
    end
    else
    begin
      awr_r <= awr_nxt;
      wr_r <= wr_nxt;
      bv_r <= bv_nxt;
      br_r <= br_nxt;
      arr_r <= arr_nxt;
      rv_r <= rv_nxt;
      rr_r <= rr_nxt;
      rd_r <= rd_nxt;
      awa_r <= awa_nxt;
      wd_r <= wd_nxt;
      ws_r <= ws_nxt;
      have_aw_r <= have_aw_nxt;
      have_w_r <= have_w_nxt;
      ctrl_r <= ctrl_nxt;
      ist_r <= ist_nxt;
      imask_r <= imask_nxt;
      txbuf_r <= txbuf_nxt;
      txpend_r <= txpend_nxt;
      rxlast_r <= rxlast_nxt;
      irq_out <= |(ist_nxt & imask_nxt);
    end
  end

  assign s_axi_awready_out = awr_r;
  assign s_axi_wready_out = wr_r;
  assign s_axi_bvalid_out = bv_r;
  assign s_axi_bresp_out = br_r;
  assign s_axi_arready_out = arr_r;
  assign s_axi_rvalid_out = rv_r;
  assign s_axi_rresp_out = rr_r;
  assign s_axi_rdata_out = rd_r;
  assign tx_data_out = txbuf_r; // RULE17
  assign tx_start_out = start_r; // RULE18
  assign local_ready_output_out = rdy_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  a_none_no_wait: assert property ( // RULE2
    (st_r == ST_IDLE && txpend_r && !menu_busy && mode == HANDSHAKE_NONE_CODE)
      |=> st_r == ST_SEND) else $error("no-handshake send waited");
  a_wait_host_low: assert property ( // RULE5
    (st_r == ST_WAITRDY && !host_ready_in) |=> st_r != ST_SEND)
    else $error("sent without host ready");
  a_ready_err_drop: assert property ( // RULE6
    (st_r == ST_WAITRDY && !host_ready_in && rdy_lim != '0 && tmr_r >= rdy_lim - 1'b1)
      |=> st_r == ST_IDLE && ist_r[SFC_IRQ_ERR]) else $error("ready timeout missed");
  a_ready_low_busy: assert property ( // RULE4
    (mode == HANDSHAKE_LINE_CODE && st_r == ST_BUSY) |-> !rdy_r)
    else $error("ready high while sending");
  a_req_before_send: assert property ( // RULE9
    (mode == HANDSHAKE_REQUEST_CODE && start_r) |-> rdy_r)
    else $error("request low at send");
  a_char_finish: assert property ( // RULE8
    (st_r == ST_BUSY && tx_busy_in) |=> st_r == ST_BUSY)
    else $error("left send mid character");
  a_ack_good: assert property ( // RULE11
    (st_r == ST_RESP && rx_valid_in && rx_data_in == SFC_CHR_ACK)
      |=> st_r == ST_IDLE && ist_r[SFC_IRQ_GOOD]) else $error("ack not completed");
  a_nak_resend: assert property ( // RULE12
    (st_r == ST_RESP && rx_valid_in && rx_data_in == SFC_CHR_NAK)
      |=> st_r == ST_SEND ##1 st_r == ST_BUSY && tx_start_out)
    else $error("nak not resent");
  a_other_ignored: assert property ( // RULE19
    (st_r == ST_RESP && rx_valid_in && rx_data_in != SFC_CHR_ACK
      && rx_data_in != SFC_CHR_NAK && rx_data_in != SFC_CHR_DC1 && rsp_lim == '0)
      |=> st_r == ST_RESP) else $error("stray char acted on");
  a_rsp_timeout: assert property ( // RULE14 RULE16
    (st_r == ST_RESP && !rx_valid_in && rsp_lim != '0 && tmr_r >= rsp_lim - 1'b1)
      |=> st_r == ST_IDLE) else $error("response timeout missed");
  a_irq_level: assert property (
    irq_out == $past(|(ist_nxt & imask_nxt))) else $error("irq mismatch");

  c_line_send: cover property (mode == HANDSHAKE_LINE_CODE && st_r == ST_BUSY);
  c_ack_good: cover property (ev_good && mode == HANDSHAKE_ACK_CODE);
  c_nak_path: cover property (st_r == ST_RESP ##1 st_r == ST_SEND);
  c_ready_timeout: cover property (ev_err && st_r == ST_WAITRDY);

endmodule

`default_nettype wire

// *** tb/sfc_host_model.sv ***
// Framer and host-response model facing the serial flow-control block
`timescale 1ns/100ps
`default_nettype none

module sfc_host_model
  import sfc_pkg::*;
#(
  parameter int BUSY_CYC = 20
)
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Framer transmit side
  input wire logic [7:0] tx_data_in,
  input wire logic tx_start_in,
  output logic tx_busy_out,
  output logic [7:0] sent_chr_out,
  output logic [7:0] sent_cnt_out,
  // Host responses
  input wire logic [7:0] resp_chr_in,
  input wire logic resp_go_in,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out
);
  int busy_cnt_r;

  // -------------------------------------------
  // Line model
  // -------------------------------------------
  // Frame time is fixed; bit rate and framing live outside the block
  always_ff @(posedge core_clk_in)
  begin
    if (!nrst_in)
    begin
      busy_cnt_r <= 0;
      tx_busy_out <= 1'b0;
      sent_chr_out <= 8'h00;
      sent_cnt_out <= 8'h00;
      rx_valid_out <= 1'b0;
      rx_data_out <= 8'h00;
    end
    else
    begin
      if (tx_start_in)
      begin
        busy_cnt_r <= BUSY_CYC;
        tx_busy_out <= 1'b1;
        sent_chr_out <= tx_data_in;
        sent_cnt_out <= sent_cnt_out + 8'h01;
      end
      else
      begin
        busy_cnt_r <= (busy_cnt_r > 0) ? busy_cnt_r - 1 : 0;
        tx_busy_out <= busy_cnt_r > 1;
      end
      // Idle receive data toggles so a stale byte is never mistaken for valid
      rx_valid_out <= resp_go_in;
      rx_data_out <= resp_go_in ? resp_chr_in : ~rx_data_out;
    end
  end
endmodule

`default_nettype wire

// *** tb/sfc_tb_top.sv ***
// Self-checking testbench for the serial flow-control block
`timescale 1ns/100ps
`default_nettype none

module sfc_tb_top
  import sfc_pkg::*;
;
  logic core_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] s_axi_awaddr_in = 8'h00;
  logic s_axi_awvalid_in = 1'b0;
  logic [31:0] s_axi_wdata_in = 32'h0;
  logic [3:0] s_axi_wstrb_in = 4'hf;
  logic s_axi_wvalid_in = 1'b0;
  logic s_axi_bready_in = 1'b0;
  logic [7:0] s_axi_araddr_in = 8'h00;
  logic s_axi_arvalid_in = 1'b0;
  logic s_axi_rready_in = 1'b0;
  logic host_ready_in = 1'b0;
  logic [7:0] resp_chr = 8'h00;
  logic resp_go = 1'b0;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out, tx_start_out, tx_busy_in, rx_valid_in;
  logic local_ready_output_out, irq_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, wr_resp, rd_resp;
  logic [31:0] s_axi_rdata_out, rd_data;
  logic [7:0] tx_data_out, rx_data_in, sent_chr, sent_cnt;
  int error_cnt = 0;
  int num_checks = 0;

  initial
  begin
    forever #5 core_clk_in = ~core_clk_in;
  end

  // Ten cycles per millisecond keep every timeout within a short run
  sfc_top #(.CYC_PER_MS(10)) dut (.core_clk_in, .nrst_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
    .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
    .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
    .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
    .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .tx_data_out,
    .tx_start_out, .tx_busy_in, .rx_data_in, .rx_valid_in, .local_ready_output_out,
    .host_ready_in, .irq_out);

  sfc_host_model u_host (.core_clk_in, .nrst_in, .tx_data_in(tx_data_out),
    .tx_start_in(tx_start_out), .tx_busy_out(tx_busy_in), .sent_chr_out(sent_chr),
    .sent_cnt_out(sent_cnt), .resp_chr_in(resp_chr), .resp_go_in(resp_go),
    .rx_data_out(rx_data_in), .rx_valid_out(rx_valid_in));

  // -------------------------------------------
  // Reporting
  // -------------------------------------------
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    error_cnt++;
    $display("[FAIL] %0t wait ran out", $time);
    summarize();
  endtask

  // -------------------------------------------
  // Bus and link tasks
  // -------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    for (int k = 0; k < 200; k++)
    begin
      @(posedge core_clk_in);
      if (s_axi_awvalid_in && s_axi_awready_out === 1'b1)
        s_axi_awvalid_in <= 1'b0;
      if (s_axi_wvalid_in && s_axi_wready_out === 1'b1)
        s_axi_wvalid_in <= 1'b0;
      if (s_axi_bvalid_out === 1'b1)
      begin
        wr_resp = s_axi_bresp_out;
        s_axi_bready_in <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge core_clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    for (int k = 0; k < 200; k++)
    begin
      @(posedge core_clk_in);
      if (s_axi_arvalid_in && s_axi_arready_out === 1'b1)
        s_axi_arvalid_in <= 1'b0;
      if (s_axi_rvalid_out === 1'b1)
      begin
        rd_data = s_axi_rdata_out;
        rd_resp = s_axi_rresp_out;
        s_axi_rready_in <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    axi_rd(a);
    chk(rd_data & m, e);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask

  // Bounded waits: either a character count reached or the interrupt line
  task automatic wait_sent(input logic [7:0] n);
    for (int k = 0; k < 500; k++)
    begin
      @(posedge core_clk_in);
      if (sent_cnt === n)
        return;
    end
    hang();
  endtask

  task automatic wait_irq();
    for (int k = 0; k < 2000; k++)
    begin
      @(posedge core_clk_in);
      if (irq_out === 1'b1)
        return;
    end
    hang();
  endtask

  task automatic respond(input logic [7:0] c);
    @(posedge core_clk_in);
    resp_chr <= c;
    resp_go <= 1'b1;
    @(posedge core_clk_in);
    resp_go <= 1'b0;
  endtask

  // -------------------------------------------
  // Scenarios
  // -------------------------------------------
  initial
  begin
    idle(12);
    nrst_in <= 1'b1;
    idle(2);
    chk(local_ready_output_out, 32'h1);
    chk(irq_out, 32'h0);
    rdchk(SFC_CTRL_OFS, 32'hffffffff, SFC_CTRL_RST);
    rdchk(SFC_STAT_OFS, 32'hff, 32'h01);
    axi_rd(8'h18);
    chk(rd_resp, SFC_RESP_SLVERR);
    axi_wr(8'h1c, 32'h0);
    chk(wr_resp, SFC_RESP_SLVERR);
    for (int m = 0; m < 5; m++)
    begin
      axi_wr(SFC_CTRL_OFS, 32'(m) | (32'(m % 4) << SFC_RWAIT_LSB) | (32'(m % 4) << SFC_AWAIT_LSB));
      rdchk(SFC_CTRL_OFS, 32'h3ff, 32'(m) | (32'(m % 4) << 4) | (32'(m % 4) << 8));
    end
    // No handshake: host not ready yet the character goes out
    axi_wr(SFC_IRQ_MASK_OFS, 32'h7);
    axi_wr(SFC_CTRL_OFS, HANDSHAKE_NONE_CODE);
    axi_wr(SFC_TXDATA_OFS, 32'h41);
    wait_sent(8'h01);
    chk(sent_chr, 8'h41);
    wait_irq();
    rdchk(SFC_IRQ_STAT_OFS, 32'h7, 32'h4);
    axi_wr(SFC_IRQ_MASK_OFS, 32'h3);
    idle(2);
    chk(irq_out, 32'h0);
    axi_wr(SFC_IRQ_STAT_OFS, 32'h4);
    axi_wr(SFC_IRQ_MASK_OFS, 32'h7);
    idle(2);
    chk(irq_out, 32'h0);
    // Ready line: hold off until host ready, ready output drops while sending
    axi_wr(SFC_CTRL_OFS, HANDSHAKE_LINE_CODE);
    axi_wr(SFC_TXDATA_OFS, 32'h52);
    idle(50);
    chk(sent_cnt, 8'h01);
    rdchk(SFC_STAT_OFS, 32'hc0, 32'h80);
    host_ready_in <= 1'b1;
    wait_sent(8'h02);
    chk(local_ready_output_out, 32'h0);
    chk(sent_chr, 8'h52);
    wait_irq();
    axi_wr(SFC_IRQ_STAT_OFS, 32'h4);
    idle(2);
    chk(local_ready_output_out, 32'h1);
    // Host drops ready mid-character: the character still completes
    axi_wr(SFC_TXDATA_OFS, 32'h53);
    wait_sent(8'h03);
    host_ready_in <= 1'b0;
    wait_irq();
    rdchk(SFC_IRQ_STAT_OFS, 32'h7, 32'h4);
    axi_wr(SFC_IRQ_STAT_OFS, 32'h4);
    axi_wr(SFC_CTRL_OFS, 32'h1000 | HANDSHAKE_LINE_CODE);
    idle(2);
    chk(local_ready_output_out, 32'h0);
    // Request line: request raised while the host still holds off
    axi_wr(SFC_CTRL_OFS, HANDSHAKE_REQUEST_CODE);
    axi_wr(SFC_TXDATA_OFS, 32'h63);
    idle(20);
    chk(local_ready_output_out, 32'h1);
    chk(sent_cnt, 8'h03);
    host_ready_in <= 1'b1;
    wait_sent(8'h04);
    wait_irq();
    axi_wr(SFC_IRQ_STAT_OFS, 32'hf);
    // Acknowledge mode: ignore noise, resend on nak, complete on ack
    axi_wr(SFC_IRQ_MASK_OFS, 32'h3);
    axi_wr(SFC_CTRL_OFS, HANDSHAKE_ACK_CODE);
    axi_wr(SFC_TXDATA_OFS, 32'h74);
    wait_sent(8'h05);
    idle(40);
    respond(8'h41);
    idle(10);
    rdchk(SFC_IRQ_STAT_OFS, 32'hf, 32'h8);
    rdchk(SFC_STAT_OFS, 32'h3f, ST_RESP);
    rdchk(SFC_RXDATA_OFS, 32'h1ff, 32'h083);
    rdchk(SFC_RXDATA_OFS, 32'h1ff, 32'h082);
    rdchk(SFC_TXDATA_OFS, 32'hff, 32'h74);
    respond(SFC_CHR_NAK);
    wait_sent(8'h06);
    chk(sent_chr, 8'h74);
    idle(40);
    respond(SFC_CHR_ACK);
    wait_irq();
    rdchk(SFC_IRQ_STAT_OFS, 32'h3, 32'h1);
    axi_wr(SFC_IRQ_STAT_OFS, 32'hf);
    axi_wr(SFC_TXDATA_OFS, 32'h30);
    wait_sent(8'h07);
    idle(40);
    respond(SFC_CHR_DC1);
    idle(10);
    rdchk(SFC_STAT_OFS, 32'h3f, ST_IDLE);
    rdchk(SFC_IRQ_STAT_OFS, 32'h3, 32'h0);
    axi_wr(SFC_CTRL_OFS, HANDSHAKE_ACK_QUIET_CODE);
    axi_wr(SFC_TXDATA_OFS, 32'h35);
    wait_sent(8'h08);
    idle(40);
    respond(SFC_CHR_ACK);
    wait_irq();
    rdchk(SFC_IRQ_STAT_OFS, 32'h3, 32'h1);
    // Short response wait: quiet mode takes the timeout as an ack
    axi_wr(SFC_IRQ_STAT_OFS, 32'hf);
    axi_wr(SFC_CTRL_OFS, HANDSHAKE_ACK_QUIET_CODE | (32'h1 << SFC_AWAIT_LSB));
    axi_wr(SFC_TXDATA_OFS, 32'h36);
    wait_sent(8'h09);
    wait_irq();
    rdchk(SFC_IRQ_STAT_OFS, 32'h3, 32'h1);
    // Plain ack mode: no event before the wait ends, then an error
    axi_wr(SFC_IRQ_STAT_OFS, 32'hf);
    axi_wr(SFC_CTRL_OFS, HANDSHAKE_ACK_CODE | (32'h1 << SFC_AWAIT_LSB));
    axi_wr(SFC_TXDATA_OFS, 32'h37);
    wait_sent(8'h0a);
    idle(900);
    rdchk(SFC_IRQ_STAT_OFS, 32'h3, 32'h0);
    wait_irq();
    rdchk(SFC_IRQ_STAT_OFS, 32'h3, 32'h2);
    rdchk(SFC_STAT_OFS, 32'h3f, ST_IDLE);
    // Ready line with a short wait: host never ready, character dropped
    axi_wr(SFC_IRQ_STAT_OFS, 32'hf);
    axi_wr(SFC_CTRL_OFS, HANDSHAKE_LINE_CODE | (32'h1 << SFC_RWAIT_LSB));
    host_ready_in <= 1'b0;
    axi_wr(SFC_TXDATA_OFS, 32'h38);
    idle(900);
    rdchk(SFC_IRQ_STAT_OFS, 32'h3, 32'h0);
    wait_irq();
    rdchk(SFC_IRQ_STAT_OFS, 32'h3, 32'h2);
    rdchk(SFC_STAT_OFS, 32'h80, 32'h0);
    chk(sent_cnt, 8'h0a);
    summarize();
  end
endmodule

`default_nettype wire
